// >>> src/dpm_defs.vh
// Constants for the dual-port memory port controller
`ifndef DPM_DEFS_VH
`define DPM_DEFS_VH
// Array geometry and mailbox words
`define DPM_ADDR_W 14
`define DPM_DATA_W 16
`define DPM_MBOX_RIGHT 14'h3FFF
`define DPM_MBOX_LEFT 14'h3FFE
`define DPM_TOKEN_ADDR_W 3
// Timing in ns (slowest grade) and clock period
`define DPM_CLK_NS 50
`define DPM_SELECT_ACCESS_DELAY_NS 20
`define DPM_OUTPUT_ENABLE_ACCESS_DELAY_NS 12
`define DPM_SELECT_TO_FLAG_DELAY_NS 20
`define DPM_TOKEN_PAUSE_TIME_NS 10
`define DPM_TOKEN_WRITE_TO_READ_DELAY_NS 10
`define DPM_WRITE_PULSE_NS 15
// Cycle counts, least times rounded up, at least one cycle
`define DPM_CYC(ns) ((((ns) + `DPM_CLK_NS - 1) / `DPM_CLK_NS) < 1 ? 1 : \
    (((ns) + `DPM_CLK_NS - 1) / `DPM_CLK_NS))
`define DPM_READ_CYC `DPM_CYC(`DPM_SELECT_ACCESS_DELAY_NS)
`define DPM_FLAG_CYC `DPM_CYC(`DPM_SELECT_TO_FLAG_DELAY_NS)
`define DPM_WRITE_CYC `DPM_CYC(`DPM_WRITE_PULSE_NS)
`define DPM_PAUSE_CYC `DPM_CYC(`DPM_TOKEN_PAUSE_TIME_NS)
`define DPM_TOKEN_READ_CYC `DPM_CYC(`DPM_TOKEN_WRITE_TO_READ_DELAY_NS + \
    `DPM_OUTPUT_ENABLE_ACCESS_DELAY_NS)
// Command codes
`define DPM_CMD_READ 2'h0
`define DPM_CMD_WRITE 2'h1
`define DPM_CMD_TOKEN_GET 2'h2
`define DPM_CMD_TOKEN_FREE 2'h3
`endif

// >>> src/dpm_port_host.v
// Host controller for one port of an asynchronous dual-port memory
// Overview of operation
// - Array read: drive port select low first, then output enable low after the settle count.
// - Token read: drive token select low instead of port select, output enable low.
// - Writes wait until the busy input has settled.
// - Request token by writing zero, read back; zero means owned, one means poll.
// - After a token write, hold select or output enable high for the pause.
// - Token select is the latch chip select; port select stays high meanwhile.
`timescale 1ns/1ns
`include "dpm_defs.vh"

module dpm_port_host #(
    parameter AW = `DPM_ADDR_W,
    parameter DW = `DPM_DATA_W,
    parameter MBOX_OWN = `DPM_MBOX_LEFT
) (
    // Clock and reset
    input wire I_CLK_SYS,
    input wire I_RESET_N,
    // User command port
    input wire I_REQ,
    input wire [1:0] I_CMD,
    input wire [AW-1:0] I_ADDR,
    input wire [DW-1:0] I_WDATA,
    output reg O_BUSY,
    output reg O_DONE,
    output reg [DW-1:0] O_RDATA,
    output reg O_TOKEN_OWNED,
    output reg O_MBOX_EVENT,
    // Memory port pins
    output reg O_CE_N,
    output reg O_TOKEN_LATCH_SELECT_N,
    output reg O_OE_N,
    output reg O_RW_N,
    output reg [AW-1:0] O_A,
    output reg [DW-1:0] O_DQ_O,
    output reg O_DQ_OE,
    input wire [DW-1:0] I_DQ,
    input wire I_CONTENTION_N,
    input wire I_MBOX_FLAG_N
);

    localparam S_IDLE = 6'h01;
    localparam S_SETTLE = 6'h02;
    localparam S_ACCESS = 6'h04;
    localparam S_PAUSE = 6'h08;
    localparam S_TREAD = 6'h10;
    localparam S_END = 6'h20;
    localparam CW = 4;

    // ===========================================
    // Input synchronisers
    reg [DW-1:0] dq_s1_q;
    reg [DW-1:0] dq_s2_q;
    reg busy_s1_q;
    reg busy_s2_q;
    reg int_s1_q;
    reg int_s2_q;
    reg int_prev_q;

    always @(posedge I_CLK_SYS or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            dq_s1_q <= {DW{1'b0}};
            dq_s2_q <= {DW{1'b0}};
            busy_s1_q <= 1'b1;
            busy_s2_q <= 1'b1;
            int_s1_q <= 1'b1;
            int_s2_q <= 1'b1;
            int_prev_q <= 1'b1;
        end else begin
            dq_s1_q <= I_DQ;
            dq_s2_q <= dq_s1_q;
            busy_s1_q <= I_CONTENTION_N;
            busy_s2_q <= busy_s1_q;
            int_s1_q <= I_MBOX_FLAG_N;
            int_s2_q <= int_s1_q;
            int_prev_q <= int_s2_q;
        end
    end

    // ===========================================
    // Sequencer
    function [CW-1:0] cyc;
        input integer n;
        begin
            cyc = n[CW-1:0];
        end
    endfunction

    reg [5:0] state_q;
    reg [CW-1:0] cnt_q;
    reg [1:0] cmd_q;
    reg [AW-1:0] addr_q;
    reg [DW-1:0] wdata_q;
    reg is_write_q;
    reg is_token_q;
    reg lost_q;

    always @(posedge I_CLK_SYS or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            state_q <= S_IDLE;
            cnt_q <= {CW{1'b0}};
            cmd_q <= 2'h0;
            addr_q <= {AW{1'b0}};
            wdata_q <= {DW{1'b0}};
            is_write_q <= 1'b0;
            is_token_q <= 1'b0;
            lost_q <= 1'b0;
            O_BUSY <= 1'b0;
            O_DONE <= 1'b0;
            O_RDATA <= {DW{1'b0}};
            O_TOKEN_OWNED <= 1'b0;
            O_MBOX_EVENT <= 1'b0;
            O_CE_N <= 1'b1;
            O_TOKEN_LATCH_SELECT_N <= 1'b1;
            O_OE_N <= 1'b1;
            O_RW_N <= 1'b1;
            O_A <= {AW{1'b0}};
            O_DQ_O <= {DW{1'b0}};
            O_DQ_OE <= 1'b0;
        end else begin
            O_DONE <= 1'b0;
            // Falling mailbox flag means the other port left a message
            O_MBOX_EVENT <= int_prev_q & ~int_s2_q;
            cnt_q <= cnt_q - {{(CW-1){1'b0}}, (cnt_q != {CW{1'b0}})};
            case (state_q)
                S_IDLE: begin
                    if (I_REQ) begin
                        cmd_q <= I_CMD;
                        addr_q <= I_ADDR;
                        wdata_q <= I_WDATA;
                        is_write_q <= (I_CMD != `DPM_CMD_READ);
                        is_token_q <= I_CMD[1];
                        lost_q <= 1'b0;
                        O_BUSY <= 1'b1;
                        O_RW_N <= 1'b1;
                        if (I_CMD[1]) begin
                            // Port select stays high for token access
                            O_TOKEN_LATCH_SELECT_N <= 1'b0;
                            O_CE_N <= 1'b1;
                            O_A <= {{(AW-3){1'b0}}, I_ADDR[2:0]};
                        end else begin
                            O_CE_N <= 1'b0;
                            O_A <= I_ADDR;
                        end
                        cnt_q <= cyc(`DPM_FLAG_CYC + 2);
                        state_q <= S_SETTLE;
                    end
                end
                S_SETTLE: begin
                    // Flag plus synchroniser delay must elapse before a write
                    if (cnt_q == {CW{1'b0}}) begin
                        lost_q <= ~busy_s2_q;
                        if (is_write_q) begin
                            O_RW_N <= 1'b0;
                            O_DQ_OE <= 1'b1;
                            // Token write carries only bit zero
                            O_DQ_O <= is_token_q ? {{(DW-1){1'b0}},
                                cmd_q == `DPM_CMD_TOKEN_FREE} : wdata_q;
                            cnt_q <= cyc(`DPM_WRITE_CYC);
                        end else begin
                            O_OE_N <= 1'b0;
                            cnt_q <= cyc(`DPM_READ_CYC + 2);
                        end
                        state_q <= S_ACCESS;
                    end
                end
                S_ACCESS: begin
                    if (cnt_q == {CW{1'b0}}) begin
                        O_RW_N <= 1'b1;
                        O_DQ_OE <= 1'b0;
                        O_OE_N <= 1'b1;
                        if (!is_write_q) begin
                            O_RDATA <= dq_s2_q;
                        end
                        if (cmd_q == `DPM_CMD_TOKEN_FREE) begin
                            O_TOKEN_OWNED <= 1'b0;
                        end
                        if (cmd_q == `DPM_CMD_TOKEN_GET) begin
                            // Deselect for the pause before read-back
                            O_TOKEN_LATCH_SELECT_N <= 1'b1;
                            cnt_q <= cyc(`DPM_PAUSE_CYC);
                            state_q <= S_PAUSE;
                        end else begin
                            state_q <= S_END;
                        end
                    end
                end
                S_PAUSE: begin
                    if (cnt_q == {CW{1'b0}}) begin
                        O_TOKEN_LATCH_SELECT_N <= 1'b0;
                        O_OE_N <= 1'b0;
                        cnt_q <= cyc(`DPM_TOKEN_READ_CYC + 2);
                        state_q <= S_TREAD;
                    end
                end
                S_TREAD: begin
                    if (cnt_q == {CW{1'b0}}) begin
                        O_OE_N <= 1'b1;
                        O_RDATA <= dq_s2_q;
                        // Zero read back means this side holds the token
                        O_TOKEN_OWNED <= ~dq_s2_q[0];
                        state_q <= S_END;
                    end
                end
                S_END: begin
                    O_CE_N <= 1'b1;
                    O_TOKEN_LATCH_SELECT_N <= 1'b1;
                    O_BUSY <= 1'b0;
                    O_DONE <= 1'b1;
                    state_q <= S_IDLE;
                end
                default: begin
                    state_q <= S_IDLE;
                end
            endcase
        end
    end

endmodule // dpm_port_host

// >>> dv/dpm_dev_model.sv
// Behavioural memory device seen from the left port
`timescale 1ns/1ns
module dpm_dev_model (
    // Left port pins
    input wire i_ce_n,
    input wire i_tok_sel_n,
    input wire i_oe_n,
    input wire i_rw_n,
    input wire [13:0] i_a,
    input wire [15:0] i_dq,
    output wire [15:0] o_dq,
    output wire o_contention_n,
    output reg o_mbox_flag_n,
    // Far side controls
    input wire i_lose,
    input wire i_peer_hold,
    input wire i_peer_mb_wr,
    output reg o_peer_flag_n
);
    reg [15:0] mem [0:16383];
    reg [7:0] own = 8'h00;
    reg [7:0] pend = 8'h00;
    reg [15:0] tok_q = 16'h0000;
    reg [15:0] wr_d = 16'h0000;
    reg [15:0] junk = 16'hA5A5;
    reg wr_ce_n = 1'b1;
    reg wr_tsel_n = 1'b1;
    wire arr_rd = !i_ce_n && !i_oe_n && i_rw_n;
    wire tok_rd = !i_tok_sel_n && i_ce_n && !i_oe_n && i_rw_n;
    initial o_mbox_flag_n = 1'b1;
    initial o_peer_flag_n = 1'b1;
    // Released bus toggles so stale data never looks valid
    always #25 junk = ~junk;
    assign o_dq = arr_rd ? mem[i_a] : (tok_rd ? tok_q : junk);
    assign o_contention_n = !(i_lose && !i_ce_n);
    always @(posedge tok_rd) tok_q = {16{!own[i_a[2:0]]}};
    // Sampled inside the pulse: host may drop data and select at write end
    always @(negedge i_rw_n) begin
        #10;
        wr_d = i_dq;
        wr_ce_n = i_ce_n;
        wr_tsel_n = i_tok_sel_n;
    end
    always @(posedge i_peer_mb_wr) o_mbox_flag_n = 1'b0;
    always @(negedge i_peer_hold) begin
        own = own | pend;
        pend = 8'h00;
    end
    always @(posedge i_oe_n) begin
        if (!i_ce_n && !i_lose && i_a == 14'h3FFE)
            o_mbox_flag_n = 1'b1;
    end
    always @(posedge i_rw_n) begin
        if (!wr_ce_n) begin
            mem[i_a] = wr_d;
            if (i_a == 14'h3FFF && !i_lose) o_peer_flag_n = 1'b0;
        end else if (!wr_tsel_n) begin
            if (wr_d[0]) own[i_a[2:0]] = 1'b0;
            else if (i_peer_hold) pend[i_a[2:0]] = 1'b1;
            else own[i_a[2:0]] = 1'b1;
        end
    end
endmodule // dpm_dev_model

// >>> dv/dpm_port_host_props.sv
// Port-level assertions for the port host
`timescale 1ns/1ns
module dpm_chk (
    input wire I_CLK_SYS, input wire I_RESET_N, input wire I_REQ,
    input wire O_BUSY, input wire O_DONE, input wire [15:0] O_RDATA,
    input wire O_TOKEN_OWNED, input wire O_MBOX_EVENT, input wire O_CE_N,
    input wire O_TOKEN_LATCH_SELECT_N, input wire O_OE_N, input wire O_RW_N,
    input wire O_DQ_OE
);
    default clocking cb @(posedge I_CLK_SYS); endclocking
    default disable iff (!I_RESET_N);
    a_req_taken: assert property (I_REQ && !O_BUSY |=> O_BUSY) else $error("req");
    a_done_pulse: assert property (O_DONE |=> !O_DONE) else $error("done");
    a_busy_done: assert property ($fell(O_BUSY) |-> O_DONE) else $error("busy");
    a_read_sel: assert property (!O_OE_N |-> O_RW_N &&
        (O_CE_N != O_TOKEN_LATCH_SELECT_N)) else $error("oe");
    a_sel_excl: assert property (!O_CE_N |-> O_TOKEN_LATCH_SELECT_N) else $error("sel");
    a_write_drive: assert property (!O_RW_N |-> O_DQ_OE && O_OE_N) else $error("wr");
    // No read may start in the cycle a token write ends or the one after
    a_token_pause: assert property ($rose(O_RW_N) && !$past(O_TOKEN_LATCH_SELECT_N) |->
        O_OE_N ##1 O_OE_N) else $error("pause");
    a_owned_zero: assert property ($rose(O_TOKEN_OWNED) |->
        O_RDATA == 16'h0000) else $error("own");
    a_idle_pins: assert property (O_DONE |->
        O_CE_N && O_TOKEN_LATCH_SELECT_N && O_OE_N) else $error("idle");
    c_owned: cover property ($rose(O_TOKEN_OWNED));
    c_event: cover property (O_MBOX_EVENT);
    c_tok_wr: cover property (!O_RW_N && !O_TOKEN_LATCH_SELECT_N);
endmodule // dpm_chk
bind dpm_port_host dpm_chk u_chk (.I_CLK_SYS(I_CLK_SYS), .I_RESET_N(I_RESET_N), .I_REQ(I_REQ),
    .O_BUSY(O_BUSY), .O_DONE(O_DONE), .O_RDATA(O_RDATA), .O_TOKEN_OWNED(O_TOKEN_OWNED),
    .O_MBOX_EVENT(O_MBOX_EVENT), .O_CE_N(O_CE_N), .O_TOKEN_LATCH_SELECT_N(O_TOKEN_LATCH_SELECT_N),
    .O_OE_N(O_OE_N), .O_RW_N(O_RW_N), .O_DQ_OE(O_DQ_OE));

// >>> dv/tb_top.sv
// Self-checking bench for the port host against the memory model
`timescale 1ns/1ns
`include "dpm_defs.vh"
module tb_top;
    reg clk = 1'b0, rst_n = 1'b0, req = 1'b0, lose = 1'b0, hold = 1'b0, mb_wr = 1'b0, ev = 1'b0;
    reg [1:0] cmd = 2'h0;
    reg [13:0] addr = 14'h0000;
    reg [15:0] wdata = 16'h0000;
    integer fail_count = 0, comparisons = 0;
    wire busy, done, owned, mb_ev, ce_n, tsel_n, oe_n, rw_n, dq_oe, cont_n, flag_n, pflag_n;
    wire [15:0] rdata, dq_o, m_dq;
    wire [13:0] a;
    wire [15:0] dq = dq_oe ? dq_o : m_dq;
    always #25 clk = ~clk;
    always @(posedge clk) if (mb_ev) ev <= 1'b1;
    dpm_port_host dut (.I_CLK_SYS(clk), .I_RESET_N(rst_n), .I_REQ(req), .I_CMD(cmd),
        .I_ADDR(addr), .I_WDATA(wdata), .O_BUSY(busy), .O_DONE(done), .O_RDATA(rdata),
        .O_TOKEN_OWNED(owned), .O_MBOX_EVENT(mb_ev), .O_CE_N(ce_n),
        .O_TOKEN_LATCH_SELECT_N(tsel_n), .O_OE_N(oe_n), .O_RW_N(rw_n), .O_A(a), .O_DQ_O(dq_o),
        .O_DQ_OE(dq_oe), .I_DQ(dq), .I_CONTENTION_N(cont_n), .I_MBOX_FLAG_N(flag_n));
    dpm_dev_model u_mem (.i_ce_n(ce_n), .i_tok_sel_n(tsel_n), .i_oe_n(oe_n), .i_rw_n(rw_n),
        .i_a(a), .i_dq(dq), .o_dq(m_dq), .o_contention_n(cont_n), .o_mbox_flag_n(flag_n),
        .i_lose(lose), .i_peer_hold(hold), .i_peer_mb_wr(mb_wr), .o_peer_flag_n(pflag_n));
    task chk(input [8*10-1:0] name, input [15:0] exp, input [15:0] got);
        begin
            comparisons = comparisons + 1;
            if (got !== exp) begin
                fail_count = fail_count + 1;
                $display("[ERR] %0s expected %h seen %h", name, exp, got);
            end
        end
    endtask
    task run(input [1:0] c, input [13:0] ad);
        integer n;
        begin
            @(posedge clk);
            req <= 1'b1;
            cmd <= c;
            addr <= ad;
            wdata <= 16'h005A ^ {2'h0, ad};
            @(posedge clk);
            req <= 1'b0;
            for (n = 0; n < 100 && done !== 1'b1; n = n + 1) @(posedge clk);
            chk("done", 16'h0001, {15'h0000, done});
        end
    endtask
    task t_array;
        begin
            run(`DPM_CMD_WRITE, 14'h1005);
            run(`DPM_CMD_WRITE, 14'h1006);
            run(`DPM_CMD_READ, 14'h1005);
            chk("array", 16'h105F, rdata);
        end
    endtask
    task t_mailbox;
        begin
            @(posedge clk);
            mb_wr <= 1'b1;
            lose <= 1'b1;
            repeat (6) @(posedge clk);
            chk("event", 16'h0001, {15'h0000, ev});
            run(`DPM_CMD_READ, `DPM_MBOX_LEFT);
            chk("flag lost", 16'h0000, {15'h0000, flag_n});
            run(`DPM_CMD_WRITE, `DPM_MBOX_RIGHT);
            chk("peer lost", 16'h0001, {15'h0000, pflag_n});
            @(posedge clk);
            lose <= 1'b0;
            run(`DPM_CMD_WRITE, `DPM_MBOX_RIGHT);
            chk("peer set", 16'h0000, {15'h0000, pflag_n});
            run(`DPM_CMD_READ, `DPM_MBOX_RIGHT);
            chk("peer mbox", 16'h3FA5, rdata);
            chk("peer kept", 16'h0000, {15'h0000, pflag_n});
            run(`DPM_CMD_READ, `DPM_MBOX_LEFT);
            chk("flag clr", 16'h0001, {15'h0000, flag_n});
        end
    endtask
    task t_token;
        begin
            @(posedge clk);
            hold <= 1'b1;
            run(`DPM_CMD_TOKEN_GET, 14'h0002);
            chk("tok held", 16'hFFFF, rdata);
            chk("not owned", 16'h0000, {15'h0000, owned});
            @(posedge clk);
            hold <= 1'b0;
            run(`DPM_CMD_TOKEN_GET, 14'h3FFA);
            chk("tok taken", 16'h0000, rdata);
            chk("owned", 16'h0001, {15'h0000, owned});
            run(`DPM_CMD_TOKEN_FREE, 14'h0002);
            chk("freed", 16'h0000, {15'h0000, owned});
        end
    endtask
    task print_verdict;
        begin
            if (fail_count == 0 && comparisons > 0)
                $display("Regression OK");
            else
                $display("Regression broken");
            $finish;
        end
    endtask
    initial begin
        #200000;
        fail_count = fail_count + 1;
        print_verdict;
    end
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        t_array;
        t_mailbox;
        t_token;
        print_verdict;
    end
endmodule // tb_top
